// ==== logic/ldo_regs_cfg.svh ====
`ifndef LDO_REGS_CFG_SVH
`define LDO_REGS_CFG_SVH

// Byte offsets on the register bus
`define OFS_ENABLE_CTRL  11'h014
`define OFS_ACTIVE_CFG   11'h100
`define OFS_LOW_POWER_REGULATOR_CFG       11'h104
`define OFS_CORE_CFG     11'h300
`define OFS_SYSTEM_CFG   11'h400

// Reset values
`define RST_ENABLE_CTRL  32'h0000_0007
`define RST_ACTIVE_CFG   32'h3f10_0e15
`define RST_LOW_POWER_REGULATOR_CFG       32'h0002_1d04
`define RST_CORE_CFG     32'h0000_0044
`define RST_SYSTEM_CFG   32'h0000_0101

// Enable control fields
`define BIT_CORE_ON      0
`define BIT_SYSTEM_ON    1

// Active configuration fields
`define BIT_ACT_SYS_DS   0
`define ACT_CORE_V_LO    2
`define ACT_CORE_V_HI    3
`define BIT_ACT_SYS_V    16

// Low-power configuration fields
`define BIT_LP_SYS_DS    0
`define BIT_LP_CORE_DS   1
`define LP_CORE_V_LO     2
`define LP_CORE_V_HI     3

// Discharge controls
`define BIT_CORE_DIS_OFF 0
`define BIT_SYS_DIS_ON   0

// Core voltage code that selects nothing
`define CORE_V_RESERVED  2'h0

`endif

// ==== logic/ldo_regs_pkg.sv ====
`default_nettype none

package ldo_regs_pkg;

  typedef logic [31:0] word_t;

  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h1,
    BUS_ACK  = 2'h2
  } bus_state_t;

  // Byte-lane merge of a bus write into a stored word
  function automatic word_t merge_bytes(input word_t old_val, input word_t wr_val, input logic [3:0] be);
    word_t res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = wr_val[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

`default_nettype wire

// ==== logic/reg_write_once.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ldo_regs_cfg.svh"

module reg_write_once (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_wr_en,
  input  wire ldo_regs_pkg::word_t  i_wdata,
  input  wire logic [3:0]           i_byteenable,
  output ldo_regs_pkg::word_t       o_value,
  output logic                      o_locked
);
  import ldo_regs_pkg::*;

  typedef struct packed {
    word_t value;
    logic  locked;
  } once_t;

  once_t st;
  once_t next_st;

  ////////////////////////////////////////////////////////////////////////
  // First write captures, every later one is dropped until reset
  always_comb begin
    next_st = st;
    if (i_wr_en && !st.locked) begin
      next_st.value  = merge_bytes(st.value, i_wdata, i_byteenable);
      next_st.locked = 1'b1;
    end
  end

  // Preset lock-free with both regulators on
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '{value: `RST_ENABLE_CTRL, locked: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign o_value  = st.value;
  assign o_locked = st.locked;

endmodule
`default_nettype wire

// ==== logic/ldo_drive_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ldo_regs_cfg.svh"

module ldo_drive_ctrl (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  input  wire ldo_regs_pkg::word_t  i_enable_ctrl,
  input  wire ldo_regs_pkg::word_t  i_active_cfg,
  input  wire ldo_regs_pkg::word_t  i_low_power_regulator_cfg,
  input  wire ldo_regs_pkg::word_t  i_core_cfg,
  input  wire ldo_regs_pkg::word_t  i_system_cfg,
  input  wire logic                 i_low_power,
  input  wire logic                 i_deep_power_down,
  input  wire logic                 i_detector_en,
  output logic                      o_core_reg_on,
  output logic                      o_system_reg_on,
  output logic [1:0]                o_core_reg_voltage_sel,
  output logic                      o_core_reg_drive_sel,
  output logic                      o_system_reg_voltage_sel,
  output logic                      o_system_reg_drive_sel,
  output logic                      o_core_discharge_off,
  output logic                      o_system_discharge_on
);
  import ldo_regs_pkg::*;

  typedef struct packed {
    logic       core_on;
    logic       sys_on;
    logic [1:0] core_v;
    logic       core_ds;
    logic       sys_v;
    logic       sys_ds;
    logic       core_dis_off;
    logic       sys_dis_on;
  } drive_t;

  drive_t st;
  drive_t next_st;
  logic   lp;
  logic [1:0] core_v_cfg;

  ////////////////////////////////////////////////////////////////////////
  // Pick the mode's settings, then apply the hardware overrides
  always_comb begin
    lp         = i_low_power || i_deep_power_down;
    core_v_cfg = lp ? i_low_power_regulator_cfg[`LP_CORE_V_HI:`LP_CORE_V_LO] : i_active_cfg[`ACT_CORE_V_HI:`ACT_CORE_V_LO];
    next_st    = st;
    next_st.core_on = i_enable_ctrl[`BIT_CORE_ON] && !i_deep_power_down;
    next_st.sys_on  = i_enable_ctrl[`BIT_SYSTEM_ON];
    // Reserved code holds the last good level rather than guessing one
    if (core_v_cfg != `CORE_V_RESERVED) begin
      next_st.core_v = core_v_cfg;
    end
    // Core is always at normal drive in Active mode
    next_st.core_ds = lp ? (i_low_power_regulator_cfg[`BIT_LP_CORE_DS] || i_detector_en) : 1'b1;
    // High level only exists in Active mode
    next_st.sys_v   = lp ? 1'b0 : i_active_cfg[`BIT_ACT_SYS_V];
    next_st.sys_ds  = (lp ? i_low_power_regulator_cfg[`BIT_LP_SYS_DS] : i_active_cfg[`BIT_ACT_SYS_DS])
                      || next_st.sys_v || i_detector_en;
    next_st.core_dis_off = i_core_cfg[`BIT_CORE_DIS_OFF];
    next_st.sys_dis_on   = i_system_cfg[`BIT_SYS_DIS_ON];
  end

  // Outputs start as the reset register contents would set them in Active mode
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '{core_on: 1'b1, sys_on: 1'b1, core_v: 2'h1, core_ds: 1'b1, sys_v: 1'b0,
              sys_ds: 1'b1, core_dis_off: 1'b0, sys_dis_on: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign o_core_reg_on            = st.core_on;
  assign o_system_reg_on          = st.sys_on;
  assign o_core_reg_voltage_sel   = st.core_v;
  assign o_core_reg_drive_sel     = st.core_ds;
  assign o_system_reg_voltage_sel = st.sys_v;
  assign o_system_reg_drive_sel   = st.sys_ds;
  assign o_core_discharge_off     = st.core_dis_off;
  assign o_system_discharge_on    = st.sys_dis_on;

endmodule
`default_nettype wire

// ==== logic/ldo_regulator_config_regs.sv ====
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "ldo_regs_cfg.svh"

module ldo_regulator_config_regs (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_arst_n,
  input  wire logic [10:0]          i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire ldo_regs_pkg::word_t  i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output ldo_regs_pkg::word_t       o_avs_readdata,
  output logic                      o_avs_waitrequest,
  input  wire logic                 i_low_power,
  input  wire logic                 i_deep_power_down,
  input  wire logic                 i_detector_en,
  output logic                      o_enable_ctrl_locked,
  output logic                      o_core_reg_on,
  output logic                      o_system_reg_on,
  output logic [1:0]                o_core_reg_voltage_sel,
  output logic                      o_core_reg_drive_sel,
  output logic                      o_system_reg_voltage_sel,
  output logic                      o_system_reg_drive_sel,
  output logic                      o_core_discharge_off,
  output logic                      o_system_discharge_on
);
  import ldo_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State of the bus slave and the read-write registers

  typedef struct packed {
    bus_state_t bus;
    word_t      rdata;
    word_t      active_cfg;
    word_t      low_power_regulator_cfg;
    word_t      core_cfg;
    word_t      system_cfg;
  } regs_t;

  regs_t st;
  regs_t next_st;
  word_t enable_ctrl;
  logic  ctrl_wr;
  logic  wr_commit;
  logic  req;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake and register updates

  // Every access takes one wait cycle; reads are registered so data is stable
  assign req               = i_avs_read || i_avs_write;
  assign o_avs_waitrequest = req && (st.bus != BUS_ACK);
  assign wr_commit         = i_avs_write && (st.bus == BUS_ACK);
  assign ctrl_wr           = wr_commit && (i_avs_address == `OFS_ENABLE_CTRL);

  always_comb begin
    next_st = st;
    unique case (st.bus)
      BUS_IDLE: begin
        if (req) begin
          next_st.bus = BUS_ACK;
          // Unmapped offsets read as zero
          next_st.rdata = '0;
          if (i_avs_read) begin
            unique case (i_avs_address)
              `OFS_ENABLE_CTRL: next_st.rdata = enable_ctrl;
              `OFS_ACTIVE_CFG:  next_st.rdata = st.active_cfg;
              `OFS_LOW_POWER_REGULATOR_CFG:      next_st.rdata = st.low_power_regulator_cfg;
              `OFS_CORE_CFG:    next_st.rdata = st.core_cfg;
              `OFS_SYSTEM_CFG:  next_st.rdata = st.system_cfg;
              default:          next_st.rdata = '0;
            endcase
          end
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        // Writes land at the edge that samples waitrequest low; unmapped ones vanish
        if (i_avs_write) begin
          unique case (i_avs_address)
            `OFS_ACTIVE_CFG: begin
              next_st.active_cfg = merge_bytes(st.active_cfg, i_avs_writedata, i_avs_byteenable);
            end
            `OFS_LOW_POWER_REGULATOR_CFG: begin
              next_st.low_power_regulator_cfg = merge_bytes(st.low_power_regulator_cfg, i_avs_writedata, i_avs_byteenable);
              // Core level is frozen while the stored drive is low
              if (!st.low_power_regulator_cfg[`BIT_LP_CORE_DS]) begin
                next_st.low_power_regulator_cfg[`LP_CORE_V_HI:`LP_CORE_V_LO] = st.low_power_regulator_cfg[`LP_CORE_V_HI:`LP_CORE_V_LO];
              end
            end
            `OFS_CORE_CFG: begin
              next_st.core_cfg = merge_bytes(st.core_cfg, i_avs_writedata, i_avs_byteenable);
            end
            `OFS_SYSTEM_CFG: begin
              next_st.system_cfg = merge_bytes(st.system_cfg, i_avs_writedata, i_avs_byteenable);
            end
            default: begin
              next_st.bus = BUS_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_st.bus = BUS_IDLE;
      end
    endcase
  end

  // Registers come up at their preset values
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '{bus: BUS_IDLE, rdata: 32'h0000_0000, active_cfg: `RST_ACTIVE_CFG,
              low_power_regulator_cfg: `RST_LOW_POWER_REGULATOR_CFG, core_cfg: `RST_CORE_CFG, system_cfg: `RST_SYSTEM_CFG};
    end else begin
      st <= next_st;
    end
  end

  assign o_avs_readdata = st.rdata;

  ////////////////////////////////////////////////////////////////////////
  // Write-once enable control

  // Software owns the bypass decision; the lock only guards against strays
  reg_write_once u_enable_ctrl (
    .i_clk_sys    (i_clk_sys),
    .i_arst_n     (i_arst_n),
    .i_wr_en      (ctrl_wr),
    .i_wdata      (i_avs_writedata),
    .i_byteenable (i_avs_byteenable),
    .o_value      (enable_ctrl),
    .o_locked     (o_enable_ctrl_locked)
  );

  ////////////////////////////////////////////////////////////////////////
  // Mode selection and regulator overrides

  ldo_drive_ctrl u_drive (
    .i_clk_sys                (i_clk_sys),
    .i_arst_n                 (i_arst_n),
    .i_enable_ctrl            (enable_ctrl),
    .i_active_cfg             (st.active_cfg),
    .i_low_power_regulator_cfg                 (st.low_power_regulator_cfg),
    .i_core_cfg               (st.core_cfg),
    .i_system_cfg             (st.system_cfg),
    .i_low_power              (i_low_power),
    .i_deep_power_down        (i_deep_power_down),
    .i_detector_en            (i_detector_en),
    .o_core_reg_on            (o_core_reg_on),
    .o_system_reg_on          (o_system_reg_on),
    .o_core_reg_voltage_sel   (o_core_reg_voltage_sel),
    .o_core_reg_drive_sel     (o_core_reg_drive_sel),
    .o_system_reg_voltage_sel (o_system_reg_voltage_sel),
    .o_system_reg_drive_sel   (o_system_reg_drive_sel),
    .o_core_discharge_off     (o_core_discharge_off),
    .o_system_discharge_on    (o_system_discharge_on)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  // Helper views of the mode and stored fields
  logic in_lp;
  assign in_lp = i_low_power || i_deep_power_down;

  a_core_on_follows: assert property (
    !i_deep_power_down ##1 !i_deep_power_down |-> o_core_reg_on == $past(enable_ctrl[`BIT_CORE_ON]))
    else $error("core regulator enable does not follow its bit");

  a_sys_on_follows: assert property (
    ##1 1'b1 |-> o_system_reg_on == $past(enable_ctrl[`BIT_SYSTEM_ON]))
    else $error("system regulator enable does not follow its bit");

  a_sys_on_reset: assert property (
    !o_enable_ctrl_locked |-> enable_ctrl[`BIT_SYSTEM_ON])
    else $error("system enable bit not set before first write");

  a_ctrl_reset_val: assert property (
    !o_enable_ctrl_locked |-> enable_ctrl == `RST_ENABLE_CTRL)
    else $error("enable control changed without a write");

  a_ctrl_write_once: assert property (
    o_enable_ctrl_locked |=> $stable(enable_ctrl) && o_enable_ctrl_locked)
    else $error("locked enable control changed");

  a_ctrl_first_write: assert property (
    ctrl_wr && !o_enable_ctrl_locked && (i_avs_byteenable == 4'hf) |=> enable_ctrl == $past(i_avs_writedata))
    else $error("first enable control write not captured");

  a_active_core_v: assert property (
    !in_lp && st.active_cfg[`ACT_CORE_V_HI:`ACT_CORE_V_LO] != `CORE_V_RESERVED ##1 !in_lp
    |-> o_core_reg_voltage_sel == $past(st.active_cfg[`ACT_CORE_V_HI:`ACT_CORE_V_LO]))
    else $error("active core level not applied");

  a_lp_core_v: assert property (
    in_lp && st.low_power_regulator_cfg[`LP_CORE_V_HI:`LP_CORE_V_LO] != `CORE_V_RESERVED
    |=> o_core_reg_voltage_sel == $past(st.low_power_regulator_cfg[`LP_CORE_V_HI:`LP_CORE_V_LO]))
    else $error("low-power core level not applied");

  a_active_sys_v: assert property (
    !in_lp |=> o_system_reg_voltage_sel == $past(st.active_cfg[`BIT_ACT_SYS_V]))
    else $error("active system level not applied");

  a_active_sys_ds: assert property (
    !in_lp && !i_detector_en && !st.active_cfg[`BIT_ACT_SYS_V]
    |=> o_system_reg_drive_sel == $past(st.active_cfg[`BIT_ACT_SYS_DS]))
    else $error("active system drive not applied");

  a_lp_core_ds: assert property (
    in_lp && !i_detector_en |=> o_core_reg_drive_sel == $past(st.low_power_regulator_cfg[`BIT_LP_CORE_DS]))
    else $error("low-power core drive not applied");

  a_lp_sys_ds: assert property (
    in_lp && !i_detector_en |=> o_system_reg_drive_sel == $past(st.low_power_regulator_cfg[`BIT_LP_SYS_DS]))
    else $error("low-power system drive not applied");

  a_discharge_map: assert property (
    ##1 1'b1 |-> o_core_discharge_off == $past(st.core_cfg[`BIT_CORE_DIS_OFF])
                 && o_system_discharge_on == $past(st.system_cfg[`BIT_SYS_DIS_ON]))
    else $error("discharge control not applied");

  a_sys_discharge: assert property (
    wr_commit && i_avs_address == `OFS_SYSTEM_CFG && i_avs_byteenable[0]
    |=> st.system_cfg[`BIT_SYS_DIS_ON] == $past(i_avs_writedata[`BIT_SYS_DIS_ON]))
    else $error("system discharge write lost");

  a_cfg_rw: assert property (
    wr_commit && i_avs_address == `OFS_ACTIVE_CFG && i_avs_byteenable == 4'hf
    |=> st.active_cfg == $past(i_avs_writedata))
    else $error("active configuration write lost");

  a_mode_switch: assert property (
    !in_lp ##1 in_lp && !i_detector_en |=> o_core_reg_drive_sel == $past(st.low_power_regulator_cfg[`BIT_LP_CORE_DS]))
    else $error("mode change did not switch settings");

  a_high_sys_normal: assert property (
    o_system_reg_voltage_sel |-> o_system_reg_drive_sel)
    else $error("system at high level without normal drive");

  a_detector_normal: assert property (
    i_detector_en |=> o_core_reg_drive_sel)
    else $error("detector enabled but core drive low");

  a_core_v_frozen: assert property (
    wr_commit && i_avs_address == `OFS_LOW_POWER_REGULATOR_CFG && !st.low_power_regulator_cfg[`BIT_LP_CORE_DS]
    |=> $stable(st.low_power_regulator_cfg[`LP_CORE_V_HI:`LP_CORE_V_LO]))
    else $error("core level changed at low drive");

  a_dpd_core_off: assert property (
    i_deep_power_down |=> !o_core_reg_on)
    else $error("core regulator on in deep power down");

  a_bus_one_wait: assert property (
    req && st.bus == BUS_IDLE |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
    else $error("access not answered after one wait cycle");

  // Read-back and decode views; a read answer holds from its ack cycle until the next access
  logic mapped;
  logic rd_ack;
  assign mapped = (i_avs_address == `OFS_ENABLE_CTRL) || (i_avs_address == `OFS_ACTIVE_CFG)
                  || (i_avs_address == `OFS_LOW_POWER_REGULATOR_CFG) || (i_avs_address == `OFS_CORE_CFG)
                  || (i_avs_address == `OFS_SYSTEM_CFG);
  assign rd_ack = i_avs_read && !o_avs_waitrequest;

  a_idle_no_wait: assert property (
    !req |-> !o_avs_waitrequest)
    else $error("wait asserted with no request");

  a_rd_ctrl_data: assert property (
    rd_ack && i_avs_address == `OFS_ENABLE_CTRL |-> o_avs_readdata == enable_ctrl)
    else $error("enable control read back wrong");

  a_rd_active_data: assert property (
    rd_ack && i_avs_address == `OFS_ACTIVE_CFG |-> o_avs_readdata == st.active_cfg)
    else $error("active configuration read back wrong");

  a_rd_lp_data: assert property (
    rd_ack && i_avs_address == `OFS_LOW_POWER_REGULATOR_CFG |-> o_avs_readdata == st.low_power_regulator_cfg)
    else $error("low-power configuration read back wrong");

  a_rd_core_data: assert property (
    rd_ack && i_avs_address == `OFS_CORE_CFG |-> o_avs_readdata == st.core_cfg)
    else $error("core configuration read back wrong");

  a_rd_sys_data: assert property (
    rd_ack && i_avs_address == `OFS_SYSTEM_CFG |-> o_avs_readdata == st.system_cfg)
    else $error("system configuration read back wrong");

  a_rd_unmapped_zero: assert property (
    rd_ack && !mapped |-> o_avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_low_power_regulator_cfg_write: assert property (
    wr_commit && i_avs_address == `OFS_LOW_POWER_REGULATOR_CFG && i_avs_byteenable == 4'hf && st.low_power_regulator_cfg[`BIT_LP_CORE_DS]
    |=> st.low_power_regulator_cfg == $past(i_avs_writedata))
    else $error("low-power configuration write lost");

  a_core_dis_write: assert property (
    wr_commit && i_avs_address == `OFS_CORE_CFG && i_avs_byteenable[0]
    |=> st.core_cfg[`BIT_CORE_DIS_OFF] == $past(i_avs_writedata[`BIT_CORE_DIS_OFF]))
    else $error("core discharge write lost");

  a_ctrl_locks: assert property (
    ctrl_wr |=> o_enable_ctrl_locked)
    else $error("enable control not locked by its write");

  a_unmapped_write: assert property (
    wr_commit && !mapped |=> $stable(st.active_cfg) && $stable(st.low_power_regulator_cfg))
    else $error("unmapped write changed a register");

  a_active_core_ds: assert property (
    !in_lp |=> o_core_reg_drive_sel)
    else $error("core drive low in Active mode");

  a_lp_sys_low: assert property (
    in_lp |=> !o_system_reg_voltage_sel)
    else $error("system high level outside Active mode");

  a_detector_sys: assert property (
    i_detector_en |=> o_system_reg_drive_sel)
    else $error("detector enabled but system drive low");

  // Main scenarios
  c_ctrl_locked:   cover property (ctrl_wr ##1 o_enable_ctrl_locked);
  c_enter_lp:      cover property (!in_lp ##1 in_lp);
  c_dpd:           cover property (i_deep_power_down ##1 !o_core_reg_on);
  c_high_sys:      cover property (o_system_reg_voltage_sel && o_system_reg_drive_sel);
  c_read_back:     cover property (i_avs_read && !o_avs_waitrequest);

endmodule
`default_nettype wire

// ==== verif/ldo_regulator_config_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ldo_regs_cfg.svh"

module ldo_regulator_config_regs_tb;
  import ldo_regs_pkg::*;

  logic        clk_sys, arst_n, avs_read, avs_write;
  logic        low_power, deep_pd, det_en, mlock;
  logic [10:0] avs_addr, wa;
  logic [3:0]  avs_be, wbe;
  logic [1:0]  mcv;
  word_t       avs_wdata, readdata, rd, seed;
  word_t       m [0:4];
  logic [10:0] addrs [0:4];
  logic        waitreq, locked, core_on, sys_on, core_ds, sys_v, sys_ds, core_dis_off, sys_dis_on;
  logic [1:0]  core_v;
  int          failures, checked, cycles, k;

  ldo_regulator_config_regs dut_u (
    .i_clk_sys(clk_sys), .i_arst_n(arst_n), .i_avs_address(avs_addr), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_wdata), .i_avs_byteenable(avs_be),
    .o_avs_readdata(readdata), .o_avs_waitrequest(waitreq), .i_low_power(low_power),
    .i_deep_power_down(deep_pd), .i_detector_en(det_en), .o_enable_ctrl_locked(locked),
    .o_core_reg_on(core_on), .o_system_reg_on(sys_on), .o_core_reg_voltage_sel(core_v),
    .o_core_reg_drive_sel(core_ds), .o_system_reg_voltage_sel(sys_v),
    .o_system_reg_drive_sel(sys_ds), .o_core_discharge_off(core_dis_off),
    .o_system_discharge_on(sys_dis_on));

  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard, generous against some 1000 cycles of traffic
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  function automatic word_t lfsr(input word_t x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task stop_test;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Bus master: request held until the rising edge that samples waitrequest low
  task bus_cycle(input logic wr, input logic [10:0] a, input word_t d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_write <= wr;
    avs_read  <= ~wr;
    avs_addr  <= a;
    avs_wdata <= d;
    avs_be    <= be;
    do @(posedge clk_sys); while (waitreq !== 1'b0);
    rd = readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Model write: lane merge, one-shot enable, core level frozen at low drive
  task model_write(input logic [10:0] a, input word_t d, input logic [3:0] be);
    word_t nv;
    for (int j = 0; j < 5; j++) begin
      if (a == addrs[j] && !(j == 0 && mlock)) begin
        nv = m[j];
        for (int b = 0; b < 4; b++) if (be[b]) nv[8*b +: 8] = d[8*b +: 8];
        if (j == 2 && !m[2][1]) nv[3:2] = m[2][3:2];
        m[j] = nv;
        if (j == 0) mlock = 1'b1;
      end
    end
  endtask

  function automatic word_t mread(input logic [10:0] a);
    for (int j = 0; j < 5; j++) if (a == addrs[j]) return m[j];
    return 32'h0000_0000;
  endfunction

  // Regulator outputs against the model after two edges of settling
  task check_outs;
    logic       lp;
    logic [1:0] code;
    logic [9:0] e;
    repeat (2) @(posedge clk_sys);
    lp   = low_power | deep_pd;
    code = lp ? m[2][3:2] : m[1][3:2];
    if (code != 2'h0) mcv = code;
    e = {mlock, m[0][0] & ~deep_pd, m[0][1], mcv, lp ? (m[2][1] | det_en) : 1'b1, ~lp & m[1][16],
         lp ? (m[2][0] | det_en) : (m[1][0] | m[1][16] | det_en), m[3][0], m[4][0]};
    @(negedge clk_sys);
    check({22'h0, locked, core_on, sys_on, core_v, core_ds, sys_v, sys_ds, core_dis_off, sys_dis_on},
          {22'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk_sys = 1'b0; arst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0;
    avs_addr = 11'h000; avs_wdata = 32'h0000_0000; avs_be = 4'h0;
    low_power = 1'b0; deep_pd = 1'b0; det_en = 1'b0; mlock = 1'b0; mcv = 2'h1;
    failures = 0; checked = 0; cycles = 0; seed = 32'h9d3e_fe0d;
    addrs = '{`OFS_ENABLE_CTRL, `OFS_ACTIVE_CFG, `OFS_LOW_POWER_REGULATOR_CFG, `OFS_CORE_CFG, `OFS_SYSTEM_CFG};
    m = '{32'h0000_0007, 32'h3f10_0e15, 32'h0002_1d04, 32'h0000_0044, 32'h0000_0101};
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Reset values, plus an unmapped read
    for (k = 0; k < 5; k++) begin
      bus_cycle(1'b0, addrs[k], 32'h0000_0000, 4'hf);
      check(rd, m[k]);
    end
    bus_cycle(1'b0, 11'h108, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0000);
    check_outs();
    $display("test reset values done");
    // Random modes and partial writes to the read-write bank
    for (int i = 0; i < 80; i++) begin
      seed = lfsr(seed);
      @(posedge clk_sys);
      low_power <= seed[4];
      deep_pd   <= seed[5] & seed[6];
      det_en    <= seed[7] & seed[8];
      check_outs();
      seed = lfsr(seed);
      wa  = (seed[2:0] % 5 == 0) ? 11'h108 : addrs[seed[2:0] % 5];
      wbe = seed[11:8];
      seed = lfsr(seed);
      bus_cycle(1'b1, wa, seed, wbe);
      model_write(wa, seed, wbe);
      check_outs();
      bus_cycle(1'b0, wa, 32'h0000_0000, 4'hf);
      check(rd, mread(wa));
    end
    $display("test random config done");
    // One-shot enable control: turn both off, later write ignored
    bus_cycle(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0000, 4'hf);
    model_write(`OFS_ENABLE_CTRL, 32'h0000_0000, 4'hf);
    check_outs();
    bus_cycle(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0007, 4'hf);
    model_write(`OFS_ENABLE_CTRL, 32'h0000_0007, 4'hf);
    bus_cycle(1'b0, `OFS_ENABLE_CTRL, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0000);
    check_outs();
    $display("test write once done");
    // Mid-run reset in Active mode, so outputs held in reset match the checks
    @(posedge clk_sys);
    arst_n    <= 1'b0;
    low_power <= 1'b0;
    deep_pd   <= 1'b0;
    det_en    <= 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    mlock = 1'b0;
    mcv   = 2'h1;
    m     = '{`RST_ENABLE_CTRL, `RST_ACTIVE_CFG, `RST_LOW_POWER_REGULATOR_CFG, `RST_CORE_CFG, `RST_SYSTEM_CFG};
    bus_cycle(1'b0, `OFS_ENABLE_CTRL, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0007);
    bus_cycle(1'b1, `OFS_ENABLE_CTRL, 32'h0000_0001, 4'hf);
    model_write(`OFS_ENABLE_CTRL, 32'h0000_0001, 4'hf);
    check_outs();
    bus_cycle(1'b0, `OFS_ENABLE_CTRL, 32'h0000_0000, 4'hf);
    check(rd, 32'h0000_0001);
    $display("test reset again done");
    stop_test();
  end

endmodule
`default_nettype wire
